// [include/dos_pkg.sv]
// Constants, types and helpers for the sixteen-channel output state selector.
// Assumes one 40 MHz clock shared with the host logic; codes are signed millivolts.
// Contract
// (RULE1) One hold/clear jumper governs all sixteen channels
// (RULE2) Clear, running: converted only with batch enable
// (RULE3) Clear, stopped: zero, or offset if unconverted
// (RULE4) Hold, stopped: keep value from before stop
// (RULE5) Hold, running: converted regardless of batch enable
// (RULE6) Host error forces every channel to zero
// (RULE7) Conversion disable per channel; all enabled after reset
// (RULE8) Output disable per channel; all enabled after reset
// (RULE9) Output-disabled channel always drives zero volts
// (RULE10) Unconverted enabled channel drives its offset value
// (RULE11) Disabled channels skipped in conversion rotation
// (RULE12) Remote link error forces every channel to zero
// (RULE13) Slot 0.5ms; period 1.5ms plus slots
// (RULE14) Linear scale: offset at 0, gain at 4000
// (RULE15) Each channel registers its last driven code
package dos_pkg;

  localparam int DOS_CHANNELS = 16;
  localparam int DOS_CH_BITS  = 4;
  localparam int DOS_DATA_BITS = 12;
  localparam int DOS_CODE_BITS = 16;
  localparam int DOS_CNT_BITS = 20;

  // Timing at the 40 MHz reference clock
  localparam int DOS_CLK_PERIOD_NS  = 25;
  localparam int DOS_SLOT_NS        = 500000;
  localparam int DOS_OVERHEAD_NS    = 1500000;
  localparam int DOS_SLOT_CYCLES     = DOS_SLOT_NS / DOS_CLK_PERIOD_NS;
  localparam int DOS_OVERHEAD_CYCLES = DOS_OVERHEAD_NS / DOS_CLK_PERIOD_NS;

  // Digital input that maps onto the gain value
  localparam int DOS_FULL_SCALE = 4000;

  typedef logic signed [DOS_CODE_BITS-1:0] dos_code_t;
  typedef logic [DOS_DATA_BITS-1:0]        dos_data_t;
  typedef logic [DOS_CH_BITS-1:0]          dos_ch_t;
  typedef logic [DOS_CHANNELS-1:0]         dos_mask_t;

  // Reset values: factory offset 0 V, gain 10 V
  localparam dos_code_t DOS_ZERO_CODE    = 16'sh0000;
  localparam dos_code_t DOS_OFFSET_RESET = 16'sh0000;
  localparam dos_code_t DOS_GAIN_RESET   = 16'sh2710;
  localparam dos_mask_t DOS_MASK_RESET   = 16'h0000;
  localparam dos_data_t DOS_DATA_RESET   = 12'h000;

  typedef enum logic [1:0] {
    DOS_HOST_RUN,
    DOS_HOST_STOP,
    DOS_HOST_ERROR
  } dos_host_mode_t;

  typedef struct packed {
    logic      wr;
    dos_mask_t convDisable;
    dos_mask_t outDisable;
  } dos_cfg_wr_t;

  typedef struct packed {
    logic      wr;
    dos_ch_t   ch;
    dos_data_t value;
  } dos_data_wr_t;

  typedef struct packed {
    logic      wr;
    dos_ch_t   ch;
    dos_code_t offset;
    dos_code_t gain;
  } dos_cal_wr_t;

  // Lowest enabled channel above (or at, when incl) the start index
  function automatic logic [DOS_CH_BITS:0] dosNextEnabled(input dos_mask_t mask,
                                                          input dos_ch_t from,
                                                          input logic incl);
    logic [DOS_CH_BITS:0] res;
    res = '0;
    for (int i = DOS_CHANNELS - 1; i >= 0; i--) begin
      if (mask[i] && ((5'(i) > {1'b0, from}) || (incl && (5'(i) == {1'b0, from})))) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  // Output code chosen for one channel from the run state and its settings
  function automatic dos_code_t dosSelect(input dos_host_mode_t mode,
                                          input logic linkErr,
                                          input logic hold,
                                          input logic batchEn,
                                          input logic outDis,
                                          input logic convDis,
                                          input dos_code_t offset,
                                          input dos_code_t conv,
                                          input dos_code_t last);
    dos_code_t res;
    res = DOS_ZERO_CODE;
    if (mode == DOS_HOST_ERROR || linkErr || outDis) begin
      res = DOS_ZERO_CODE;
    end else if (convDis) begin
      res = offset;
    end else if (hold) begin
      res = (mode == DOS_HOST_RUN) ? conv : last;
    end else if (mode == DOS_HOST_RUN) begin
      res = batchEn ? conv : offset;
    end else begin
      res = DOS_ZERO_CODE;
    end
    return res;
  endfunction

endpackage

// [design/dos_scale.sv]
// Linear digital-to-code scaling between offset and gain points.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module dos_scale
  import dos_pkg::*;
(
  // Conversion input
  input  wire dos_data_t dataIn,
  input  wire dos_code_t offset,
  input  wire dos_code_t gain,
  // Result
  output var  dos_code_t codeOut
);

  logic signed [16:0] span;
  logic signed [29:0] prod;
  logic signed [29:0] quot;
  logic signed [29:0] sum;

  // Offset at input 0, gain at full scale [RULE14]
  assign span = {gain[15], gain} - {offset[15], offset};
  assign prod = 30'(span) * $signed({18'h0, dataIn});
  assign quot = prod / $signed(30'(DOS_FULL_SCALE));
  assign sum  = quot + 30'(offset);

  // Inputs above full scale may overshoot; saturate rather than wrap
  assign codeOut = (sum > 30'sd32767) ? 16'sh7fff :
                   (sum < -30'sd32768) ? 16'sh8000 : sum[15:0];

endmodule
`default_nettype wire

// [design/dos_scheduler.sv]
// Conversion rotation: an overhead gap, then one slot per enabled channel.
// Assumes the enable mask comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dos_scheduler
  import dos_pkg::*;
#(
  parameter int SLOT_CYCLES     = DOS_SLOT_CYCLES,
  parameter int OVERHEAD_CYCLES = DOS_OVERHEAD_CYCLES
) (
  // Clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  // Channels that take part in the rotation
  input  wire dos_mask_t enMask,
  // Slot start
  output logic           convStrobe,
  output var dos_ch_t    servCh
);

  typedef enum logic {SCH_OVERHEAD, SCH_SERVE} dos_sch_state_t;

  dos_sch_state_t            state_reg;
  logic [DOS_CNT_BITS-1:0]   cnt_reg;
  dos_ch_t                   ch_reg;
  logic                      strobe_reg;
  logic [DOS_CH_BITS:0]      firstEn;
  logic [DOS_CH_BITS:0]      afterEn;
  logic                      cntDone;

  assign cntDone = (state_reg == SCH_OVERHEAD) ? (cnt_reg == DOS_CNT_BITS'(OVERHEAD_CYCLES - 1))
                                               : (cnt_reg == DOS_CNT_BITS'(SLOT_CYCLES - 1));
  // Disabled channels are never picked [RULE11]
  assign firstEn = dosNextEnabled(enMask, 4'h0, 1'b1);
  assign afterEn = dosNextEnabled(enMask, ch_reg, 1'b0);
  assign convStrobe = strobe_reg;
  assign servCh = ch_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= SCH_OVERHEAD;
      cnt_reg    <= '0;
      ch_reg     <= '0;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= 1'b0;
      cnt_reg    <= cntDone ? '0 : cnt_reg + 1'b1;
      // Period is overhead plus one slot per enabled channel [RULE13]
      case (state_reg)
        SCH_OVERHEAD: begin
          if (cntDone && firstEn[DOS_CH_BITS]) begin
            state_reg  <= SCH_SERVE;
            ch_reg     <= firstEn[DOS_CH_BITS-1:0];
            strobe_reg <= 1'b1;
          end
        end
        SCH_SERVE: begin
          if (cntDone && afterEn[DOS_CH_BITS]) begin
            ch_reg     <= afterEn[DOS_CH_BITS-1:0];
            strobe_reg <= 1'b1;
          end else if (cntDone) begin
            state_reg <= SCH_OVERHEAD;
          end
        end
        default: state_reg <= SCH_OVERHEAD;
      endcase
    end
  end

endmodule
`default_nettype wire

// [design/dos_output_selector.sv]
// Top of the sixteen-channel output state selector.
// Assumes host writes, run state, batch enable and link error come from same-clock
// logic; only the hold/clear jumper is an asynchronous pin.
`timescale 1ns/10ps
`default_nettype none
module dos_output_selector
  import dos_pkg::*;
#(
  parameter int SLOT_CYCLES     = DOS_SLOT_CYCLES,
  parameter int OVERHEAD_CYCLES = DOS_OVERHEAD_CYCLES
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // Module-wide jumper, 1 selects hold
  input  wire logic            holdJumper,
  // Host run state and flags
  input  wire dos_host_mode_t  hostMode,
  input  wire logic            batchOutputEnable,
  input  wire logic            linkError,
  // Host writes
  input  wire dos_cfg_wr_t     cfgWr,
  input  wire dos_data_wr_t    dataWr,
  input  wire dos_cal_wr_t     calWr,
  // Channel outputs
  output var dos_code_t [DOS_CHANNELS-1:0] anaOut,
  // Status
  output var dos_mask_t        convEnable,
  output var dos_mask_t        outEnable,
  output logic                 holdActive,
  output logic                 convStrobe,
  output var dos_ch_t          servCh
);

  logic      holdMeta_reg;
  logic      holdSync_reg;
  dos_mask_t convDis_reg;
  dos_mask_t outDis_reg;
  dos_data_t data_reg [DOS_CHANNELS];
  dos_code_t offset_reg [DOS_CHANNELS];
  dos_code_t gain_reg [DOS_CHANNELS];
  dos_code_t convVal_reg [DOS_CHANNELS];
  dos_code_t [DOS_CHANNELS-1:0] out_reg;
  dos_code_t [DOS_CHANNELS-1:0] out_next;
  dos_code_t scaled;
  logic      convTake;

  // Jumper is a pin: two flops before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdMeta_reg <= 1'b0;
      holdSync_reg <= 1'b0;
    end else begin
      holdMeta_reg <= holdJumper;
      holdSync_reg <= holdMeta_reg;
    end
  end

  // One jumper for every channel [RULE1]
  assign holdActive = holdSync_reg;

  // Per-channel disable settings, all channels enabled out of reset [RULE7] [RULE8]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convDis_reg <= DOS_MASK_RESET;
      outDis_reg  <= DOS_MASK_RESET;
    end else if (cfgWr.wr) begin
      convDis_reg <= cfgWr.convDisable;
      outDis_reg  <= cfgWr.outDisable;
    end
  end

  assign convEnable = ~convDis_reg;
  assign outEnable  = ~outDis_reg;

  dos_scheduler #(
    .SLOT_CYCLES     (SLOT_CYCLES),
    .OVERHEAD_CYCLES (OVERHEAD_CYCLES)
  ) u_sched (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .enMask     (convEnable),
    .convStrobe (convStrobe),
    .servCh     (servCh)
  );

  // One shared converter serves the current slot's channel
  dos_scale u_scale (
    .dataIn  (data_reg[servCh]),
    .offset  (offset_reg[servCh]),
    .gain    (gain_reg[servCh]),
    .codeOut (scaled)
  );

  // Mask may drop the channel on the edge that starts its slot; then it is not converted [RULE7]
  assign convTake = convStrobe && !convDis_reg[servCh];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DOS_CHANNELS; i++) begin
        data_reg[i]    <= DOS_DATA_RESET;
        offset_reg[i]  <= DOS_OFFSET_RESET;
        gain_reg[i]    <= DOS_GAIN_RESET;
        convVal_reg[i] <= DOS_ZERO_CODE;
      end
    end else begin
      if (dataWr.wr) begin
        data_reg[dataWr.ch] <= dataWr.value;
      end
      if (calWr.wr) begin
        offset_reg[calWr.ch] <= calWr.offset;
        gain_reg[calWr.ch]   <= calWr.gain;
      end
      if (convTake) begin
        convVal_reg[servCh] <= scaled; // [RULE14]
      end
    end
  end

  // Output choice per channel; the held value is the channel's own output flop
  // [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE9] [RULE10] [RULE12]
  for (genvar g = 0; g < DOS_CHANNELS; g++) begin : g_sel
    assign out_next[g] = dosSelect(hostMode, linkError, holdSync_reg, batchOutputEnable,
                                   outDis_reg[g], convDis_reg[g], offset_reg[g],
                                   convVal_reg[g], out_reg[g]);
  end

  // Last driven code kept so hold needs no host rewrite [RULE15]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign anaOut = out_reg;

  // Checks, watching channel 0 where one channel stands for all

  logic                    ch0Enabled;
  logic                    ch0Quiet;
  logic [DOS_CNT_BITS-1:0] gap_reg;
  logic                    seen_reg;

  assign ch0Enabled = !outDis_reg[0] && !convDis_reg[0];
  assign ch0Quiet   = !linkError && hostMode != DOS_HOST_ERROR;

  // Cycles since the last slot start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg  <= '0;
      seen_reg <= 1'b0;
    end else if (convStrobe) begin
      gap_reg  <= '0;
      seen_reg <= 1'b1;
    end else if (gap_reg != '1) begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  sequence s_hold_running;
    holdSync_reg && ch0Enabled && ch0Quiet && hostMode == DOS_HOST_RUN;
  endsequence

  sequence s_hold_stopped;
    holdSync_reg && ch0Enabled && ch0Quiet && hostMode == DOS_HOST_STOP && !cfgWr.wr;
  endsequence

  a_error_all_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
    hostMode == DOS_HOST_ERROR |=> anaOut == '0)
    else $error("host error did not zero all channels");

  a_link_all_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
    linkError |=> anaOut == '0)
    else $error("link error did not zero all channels");

  a_outdis_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
    outDis_reg[0] |=> anaOut[0] == DOS_ZERO_CODE)
    else $error("output-disabled channel not at zero");

  a_convdis_offset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE10]
    !outDis_reg[0] && convDis_reg[0] && ch0Quiet |=> anaOut[0] == $past(offset_reg[0]))
    else $error("conversion-disabled channel not at offset");

  a_clear_run_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
    !holdSync_reg && ch0Enabled && ch0Quiet && hostMode == DOS_HOST_RUN
    |=> anaOut[0] == ($past(batchOutputEnable) ? $past(convVal_reg[0]) : $past(offset_reg[0])))
    else $error("clear run output not gated by batch enable");

  a_clear_stop_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    !holdSync_reg && ch0Enabled && ch0Quiet && hostMode == DOS_HOST_STOP
    |=> anaOut[0] == DOS_ZERO_CODE)
    else $error("clear stop output not zero");

  a_hold_run_conv: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
    s_hold_running |=> anaOut[0] == $past(convVal_reg[0]))
    else $error("hold run output not the converted value");

  a_hold_keep_value: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
    s_hold_running ##1 s_hold_stopped [*2] |-> anaOut[0] == $past(anaOut[0]))
    else $error("hold stop did not keep the pre-stop value");

  a_hold_one_jumper: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
    holdActive == $past(holdMeta_reg))
    else $error("hold setting not taken from the jumper synchroniser");

  a_skip_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
    convStrobe && !$past(cfgWr.wr) |-> !convDis_reg[servCh])
    else $error("disabled channel given a conversion slot");

  a_slot_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
    convStrobe && seen_reg |-> gap_reg >= DOS_CNT_BITS'(SLOT_CYCLES - 1))
    else $error("conversion slots closer than one slot time");

  a_reset_enabled: assert property (@(posedge ref_clk) // [RULE7] [RULE8]
    $rose(rst_n) |-> convEnable == '1 && outEnable == '1)
    else $error("channels not all enabled after reset");

endmodule
`default_nettype wire

// [dv/dos_host_model.sv]
// Host-side model issuing mask, data and calibration writes to the selector.
// Assumes the selector samples on the rising edge; writes change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module dos_host_model
  import dos_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // Write strobes
  output var dos_cfg_wr_t  cfgWr,
  output var dos_data_wr_t dataWr,
  output var dos_cal_wr_t  calWr
);
  initial begin
    cfgWr = '0;
    dataWr = '0;
    calWr = '0;
  end

  // Fields are scrambled once the strobe drops, so stale values never look valid
  task automatic writeCfg(input dos_mask_t convDis, input dos_mask_t outDis);
    @(negedge ref_clk);
    cfgWr <= '{1'b1, convDis, outDis};
    @(negedge ref_clk);
    cfgWr <= '{1'b0, ~convDis, ~outDis};
  endtask

  task automatic writeData(input dos_ch_t ch, input dos_data_t value);
    @(negedge ref_clk);
    dataWr <= '{1'b1, ch, value};
    @(negedge ref_clk);
    dataWr <= '{1'b0, ~ch, ~value};
  endtask

  task automatic writeCal(input dos_ch_t ch, input dos_code_t offset, input dos_code_t gain);
    @(negedge ref_clk);
    calWr <= '{1'b1, ch, offset, gain};
    @(negedge ref_clk);
    calWr <= '{1'b0, ~ch, ~offset, ~gain};
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the output state selector with shortened rotation counts.
// Assumes the host model drives all writes; run state and jumper change on falling edges.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
  import dos_pkg::*;
  localparam int SLOT = 20;
  localparam int OVER = 60;
  localparam dos_code_t OFS = 16'sh03e8;
  localparam dos_code_t GAIN = 16'sh2710;
  typedef struct packed {dos_ch_t ch; dos_code_t v;} dos_note_t;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic holdJumper = 1'b0;
  dos_host_mode_t hostMode = DOS_HOST_RUN;
  logic batchOutputEnable = 1'b1;
  logic linkError = 1'b0;
  dos_cfg_wr_t cfgWr;
  dos_data_wr_t dataWr;
  dos_cal_wr_t calWr;
  dos_code_t [DOS_CHANNELS-1:0] anaOut;
  dos_mask_t convEnable;
  dos_mask_t outEnable;
  logic holdActive;
  logic convStrobe;
  dos_ch_t servCh;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd64060;
  dos_code_t tbConv[DOS_CHANNELS];
  dos_code_t tbLast[DOS_CHANNELS];
  dos_mask_t cDis = '0;
  dos_mask_t oDis = '0;
  dos_mask_t prevEn = '1;
  dos_note_t q[$];
  dos_note_t note;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  dos_output_selector #(.SLOT_CYCLES(SLOT), .OVERHEAD_CYCLES(OVER)) dos_output_selector_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .holdJumper(holdJumper), .hostMode(hostMode),
    .batchOutputEnable(batchOutputEnable), .linkError(linkError), .cfgWr(cfgWr), .dataWr(dataWr),
    .calWr(calWr), .anaOut(anaOut), .convEnable(convEnable), .outEnable(outEnable),
    .holdActive(holdActive), .convStrobe(convStrobe), .servCh(servCh));
  dos_host_model dos_host_model_i (.ref_clk(ref_clk), .cfgWr(cfgWr), .dataWr(dataWr), .calWr(calWr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected output of one channel under the current settings
  function automatic dos_code_t want(int ch);
    if (hostMode == DOS_HOST_ERROR || linkError || oDis[ch]) return DOS_ZERO_CODE;
    if (cDis[ch]) return OFS;
    if (holdJumper) return (hostMode == DOS_HOST_RUN) ? tbConv[ch] : tbLast[ch];
    if (hostMode == DOS_HOST_RUN) return batchOutputEnable ? tbConv[ch] : OFS;
    return DOS_ZERO_CODE;
  endfunction

  // Four edges cover the jumper synchroniser plus the output register
  task automatic checkAll();
    repeat (4) @(negedge ref_clk);
    for (int ch = 0; ch < DOS_CHANNELS; ch++) begin
      tbLast[ch] = want(ch);
      q.push_back(dos_note_t'{dos_ch_t'(ch), tbLast[ch]});
    end
  endtask

  task automatic loadData();
    int v;
    for (int ch = 0; ch < DOS_CHANNELS; ch++) begin
      v = int'(rnd() % 32'd4001);
      dos_host_model_i.writeData(dos_ch_t'(ch), dos_data_t'(v));
      tbConv[ch] = dos_code_t'(1000 + 9000 * v / 4000);
    end
    repeat (OVER + DOS_CHANNELS * SLOT + 10) @(negedge ref_clk);
  endtask

  task automatic waitStrobe(input dos_ch_t c, output int t);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(negedge ref_clk);
      if (convStrobe === 1'b1 && servCh === c) break;
    end
    if (n == 2000) err_total++;
    t = cyc;
  endtask

  always @(negedge ref_clk) begin
    #2;
    while (q.size() > 0) begin
      note = q.pop_front();
      `CHK(anaOut[note.ch], note.v)
    end
  end

  // A strobe must never name a channel left out of the rotation
  always @(negedge ref_clk) begin
    if (rst_n && convStrobe === 1'b1 && convEnable === prevEn) `CHK(convEnable[servCh], 1'b1)
    prevEn <= convEnable;
  end

  task automatic summarize();
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    summarize();
  end

  initial begin
    int t0;
    int t1;
    int nEn;
    dos_ch_t low;
    repeat (5) @(negedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK(convEnable, 16'hffff)
    `CHK(outEnable, 16'hffff)
    for (int ch = 0; ch < DOS_CHANNELS; ch++) dos_host_model_i.writeCal(dos_ch_t'(ch), OFS, GAIN);
    loadData();
    checkAll();
    batchOutputEnable <= 1'b0;
    checkAll();
    batchOutputEnable <= 1'b1;
    hostMode <= DOS_HOST_STOP;
    checkAll();
    hostMode <= DOS_HOST_RUN;
    holdJumper <= 1'b1;
    batchOutputEnable <= 1'b0;
    checkAll();
    `CHK(holdActive, 1'b1)
    hostMode <= DOS_HOST_STOP;
    checkAll();
    loadData();
    checkAll();
    hostMode <= DOS_HOST_RUN;
    checkAll();
    hostMode <= DOS_HOST_ERROR;
    checkAll();
    hostMode <= DOS_HOST_RUN;
    linkError <= 1'b1;
    checkAll();
    linkError <= 1'b0;
    cDis = 16'(rnd()) & 16'h7fff;
    oDis = 16'(rnd());
    dos_host_model_i.writeCfg(cDis, oDis);
    @(negedge ref_clk);
    `CHK(convEnable, ~cDis)
    `CHK(outEnable, ~oDis)
    checkAll();
    hostMode <= DOS_HOST_STOP;
    checkAll();
    holdJumper <= 1'b0;
    checkAll();
    hostMode <= DOS_HOST_RUN;
    nEn = 0;
    low = 4'hf;
    for (int i = DOS_CHANNELS - 1; i >= 0; i--) begin
      if (!cDis[i]) begin
        nEn++;
        low = dos_ch_t'(i);
      end
    end
    waitStrobe(low, t0);
    waitStrobe(low, t0);
    waitStrobe(low, t1);
    `CHK(t1 - t0, OVER + SLOT * nEn)
    repeat (3) @(negedge ref_clk);
    summarize();
  end
endmodule
`default_nettype wire
